/* File: verilog/vio_pkg.sv */
// constants, register map and event carrier for the virtual logic i/o bank
package vio_pkg;

  // sizes
  localparam int unsigned CHANNELS = 32;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned STAMP_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] VIN_SET_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] VIN_CLR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] VIN_MODE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] VIN_LEVEL_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] VOUT_LEVEL_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] EVT_FILTER_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] ROUTE_BLOCK_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] ROUTE_GROUP_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] ROUTE_RELAY_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] ROUTE_LED_OFS = 8'h2C;
  localparam logic [ADDR_W-1:0] MS_STAMP_OFS = 8'h30;

  // reset values
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [CHANNELS-1:0] MODE_RST = 32'h0000_0000;
  localparam logic [1:0] FILTER_RST = 2'h3;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // field positions
  localparam int unsigned FILT_ON_BIT = 0;
  localparam int unsigned FILT_OFF_BIT = 1;
  localparam int unsigned IRQ_SENT_BIT = 0;
  localparam int unsigned IRQ_LOST_BIT = 1;
  localparam int unsigned FILT_W = 2;
  localparam int unsigned IRQ_W = 2;

  // event group codes
  localparam logic GROUP_OUTPUT = 1'b0;
  localparam logic GROUP_INPUT = 1'b1;

  // timing
  localparam int unsigned MS_IN_NS = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_CYCLES_DEF = MS_IN_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MS_DEF = 5;

  // one event record handed to the main event buffer
  typedef struct packed {
    logic group;
    logic [IDX_W-1:0] index;
    logic rising;
    logic [STAMP_W-1:0] stamp;
  } vio_event_s;

endpackage

/* File: verilog/event_capture.sv */
// edge capture with per-signal pending store and lowest-index hand-out
`timescale 1ns/1ps
module event_capture import vio_pkg::*; #(
  parameter int unsigned N = CHANNELS,
  parameter int unsigned IW = IDX_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // watched levels and time base
  input wire logic [N-1:0] level_i,
  input wire logic [STAMP_W-1:0] stamp_i,
  input wire logic on_en_i,
  input wire logic off_en_i,
  // hand-out
  input wire logic pop_i,
  output logic pend_o,
  output logic [IW-1:0] index_o,
  output logic rising_o,
  output logic [STAMP_W-1:0] stamp_o,
  output logic lost_o
);

  logic [N-1:0] prev_r;
  logic [N-1:0] pend_r;
  logic [N-1:0] rise_r;
  logic [N-1:0] take;
  logic [N-1:0] pop_vec;
  logic [STAMP_W-1:0] stamp_mem [N];

  // edges that pass the filter
  always_comb begin
    take = (level_i & ~prev_r & {N{on_en_i}}) | (~level_i & prev_r & {N{off_en_i}});
  end

  // lowest pending index goes first
  always_comb begin
    index_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        index_o = IW'(i);
      end
    end
  end

  assign pend_o = |pend_r;
  assign rising_o = rise_r[index_o];
  assign stamp_o = stamp_mem[index_o];

  always_comb begin
    pop_vec = (pop_i && pend_o) ? (N'(1) << index_o) : '0;
  end

  // previous level, zero after reset so no bogus edge
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= level_i;
    end
  end

  // pending flags: a new edge wins over the pop of the same signal
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pend_r <= '0;
      rise_r <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (take[i]) begin
          pend_r[i] <= 1'b1;
          rise_r[i] <= level_i[i];
        end else if (pop_vec[i]) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // stamp taken at the cycle the change is seen
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < N; i++) begin
      if (take[i]) begin
        stamp_mem[i] <= stamp_i;
      end
    end
  end

  // newer edge overwrote an unsent one
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lost_o <= 1'b0;
    end else begin
      lost_o <= |(take & pend_r & ~pop_vec);
    end
  end

endmodule

/* File: verilog/virtual_logic_io_bank.sv */
// virtual input/output bank with apb registers, pulse timers and event stream
`timescale 1ns/1ps
module virtual_logic_io_bank import vio_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
  parameter int unsigned PULSE_MS = PULSE_MS_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // mimic switch commands, one-cycle pulses
  input wire logic [CHANNELS-1:0] mimic_set_i,
  input wire logic [CHANNELS-1:0] mimic_clr_i,
  // user logic side
  input wire logic [CHANNELS-1:0] vout_i,
  output logic [CHANNELS-1:0] vin_o,
  // consumers of the virtual outputs
  output logic [CHANNELS-1:0] block_o,
  output logic [CHANNELS-1:0] group_sel_o,
  output logic [CHANNELS-1:0] relay_o,
  output logic [CHANNELS-1:0] led_o,
  // event stream to the main event buffer
  output logic event_valid_o,
  output vio_event_s event_o,
  input wire logic event_ready_i,
  // interrupt
  output logic irq_o
);

  localparam int unsigned MSW = $clog2(MS_CYCLES + 1);
  localparam int unsigned PCW = $clog2(PULSE_MS + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
  localparam logic [PCW-1:0] PULSE_LAST = PCW'(PULSE_MS - 1);

  // apb decode
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      VIN_SET_OFS, VIN_CLR_OFS, VIN_MODE_OFS, VIN_LEVEL_OFS, VOUT_LEVEL_OFS,
      EVT_FILTER_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS, ROUTE_BLOCK_OFS,
      ROUTE_GROUP_OFS, ROUTE_RELAY_OFS, ROUTE_LED_OFS, MS_STAMP_OFS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  logic pready_r;
  logic pslverr_r;
  logic [DATA_W-1:0] prdata_r;
  logic acc_first;
  logic wr_en;
  logic [DATA_W-1:0] rd_mux;

  logic [MSW-1:0] ms_cnt_r;
  logic ms_tick_r;
  logic [STAMP_W-1:0] stamp_r;

  logic [CHANNELS-1:0] vin_r;
  logic [CHANNELS-1:0] mode_r;
  logic [PCW-1:0] pcnt_r [CHANNELS];
  logic [CHANNELS-1:0] set_cmd;
  logic [CHANNELS-1:0] clr_cmd;

  logic [CHANNELS-1:0] vout_r;
  logic [CHANNELS-1:0] route_block_r;
  logic [CHANNELS-1:0] route_group_r;
  logic [CHANNELS-1:0] route_relay_r;
  logic [CHANNELS-1:0] route_led_r;

  logic [FILT_W-1:0] filter_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  logic out_pend;
  logic [IDX_W-1:0] out_idx;
  logic out_rise;
  logic [STAMP_W-1:0] out_stamp;
  logic out_lost;
  logic in_pend;
  logic [IDX_W-1:0] in_idx;
  logic in_rise;
  logic [STAMP_W-1:0] in_stamp;
  logic in_lost;
  logic load_slot;
  logic out_pop;
  logic in_pop;
  logic event_valid_r;
  vio_event_s event_r;

  // one wait state: answer in the second access cycle
  assign acc_first = psel_i && penable_i && !pready_r;
  assign wr_en = psel_i && penable_i && pwrite_i && pready_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign prdata_o = prdata_r;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc_first;
      pslverr_r <= acc_first && !is_mapped(paddr_i);
    end
  end

  // read mux; write-only command words read as zero
  always_comb begin
    case (paddr_i)
      VIN_MODE_OFS: rd_mux = mode_r;
      VIN_LEVEL_OFS: rd_mux = vin_r;
      VOUT_LEVEL_OFS: rd_mux = vout_r;
      EVT_FILTER_OFS: rd_mux = {{(DATA_W - FILT_W){1'b0}}, filter_r};
      IRQ_STATUS_OFS: rd_mux = {{(DATA_W - IRQ_W){1'b0}}, irq_status_r};
      IRQ_MASK_OFS: rd_mux = {{(DATA_W - IRQ_W){1'b0}}, irq_mask_r};
      ROUTE_BLOCK_OFS: rd_mux = route_block_r;
      ROUTE_GROUP_OFS: rd_mux = route_group_r;
      ROUTE_RELAY_OFS: rd_mux = route_relay_r;
      ROUTE_LED_OFS: rd_mux = route_led_r;
      MS_STAMP_OFS: rd_mux = stamp_r;
      default: rd_mux = WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prdata_r <= WORD_ZERO;
    end else if (acc_first) begin
      prdata_r <= (pwrite_i) ? WORD_ZERO : rd_mux;
    end
  end

  // free-running millisecond tick and time stamp counter
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else if (ms_cnt_r == MS_LAST) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b1;
    end else begin
      ms_cnt_r <= ms_cnt_r + MSW'(1);
      ms_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stamp_r <= '0;
    end else if (ms_tick_r) begin
      stamp_r <= stamp_r + STAMP_W'(1);
    end
  end

  // commands merge mimic and supervisory writes; same clock, no sync needed
  always_comb begin
    set_cmd = mimic_set_i | ((wr_en && paddr_i == VIN_SET_OFS) ? pwdata_i : WORD_ZERO);
    clr_cmd = mimic_clr_i | ((wr_en && paddr_i == VIN_CLR_OFS) ? pwdata_i : WORD_ZERO);
  end

  // virtual inputs; set beats clear when both hit one bit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vin_r <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        pcnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (set_cmd[i]) begin
          vin_r[i] <= 1'b1;
          pcnt_r[i] <= '0;
        end else if (clr_cmd[i]) begin
          vin_r[i] <= 1'b0;
          pcnt_r[i] <= '0;
        end else if (vin_r[i] && mode_r[i] && ms_tick_r) begin
          if (pcnt_r[i] == PULSE_LAST) begin
            vin_r[i] <= 1'b0;
            pcnt_r[i] <= '0;
          end else begin
            pcnt_r[i] <= pcnt_r[i] + PCW'(1);
          end
        end
      end
    end
  end

  assign vin_o = vin_r;

  // mode and filter registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_r <= MODE_RST;
      filter_r <= FILTER_RST;
    end else if (wr_en) begin
      if (paddr_i == VIN_MODE_OFS) begin
        mode_r <= pwdata_i;
      end
      if (paddr_i == EVT_FILTER_OFS) begin
        filter_r <= pwdata_i[FILT_W-1:0];
      end
    end
  end

  // route masks
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      route_block_r <= WORD_ZERO;
      route_group_r <= WORD_ZERO;
      route_relay_r <= WORD_ZERO;
      route_led_r <= WORD_ZERO;
    end else if (wr_en) begin
      if (paddr_i == ROUTE_BLOCK_OFS) begin
        route_block_r <= pwdata_i;
      end
      if (paddr_i == ROUTE_GROUP_OFS) begin
        route_group_r <= pwdata_i;
      end
      if (paddr_i == ROUTE_RELAY_OFS) begin
        route_relay_r <= pwdata_i;
      end
      if (paddr_i == ROUTE_LED_OFS) begin
        route_led_r <= pwdata_i;
      end
    end
  end

  // virtual outputs sampled, then gated onto each consumer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vout_r <= '0;
    end else begin
      vout_r <= vout_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      block_o <= '0;
      group_sel_o <= '0;
      relay_o <= '0;
      led_o <= '0;
    end else begin
      block_o <= vout_r & route_block_r;
      group_sel_o <= vout_r & route_group_r;
      relay_o <= vout_r & route_relay_r;
      led_o <= vout_r & route_led_r;
    end
  end

  // edge capture for each group
  event_capture #(.N(CHANNELS), .IW(IDX_W)) out_cap (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(vout_r),
    .stamp_i(stamp_r),
    .on_en_i(filter_r[FILT_ON_BIT]),
    .off_en_i(filter_r[FILT_OFF_BIT]),
    .pop_i(out_pop),
    .pend_o(out_pend),
    .index_o(out_idx),
    .rising_o(out_rise),
    .stamp_o(out_stamp),
    .lost_o(out_lost)
  );

  event_capture #(.N(CHANNELS), .IW(IDX_W)) in_cap (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(vin_r),
    .stamp_i(stamp_r),
    .on_en_i(filter_r[FILT_ON_BIT]),
    .off_en_i(filter_r[FILT_OFF_BIT]),
    .pop_i(in_pop),
    .pend_o(in_pend),
    .index_o(in_idx),
    .rising_o(in_rise),
    .stamp_o(in_stamp),
    .lost_o(in_lost)
  );

  // output group has priority; slot refills when empty or accepted
  assign load_slot = !event_valid_r || event_ready_i;
  assign out_pop = load_slot && out_pend;
  assign in_pop = load_slot && !out_pend && in_pend;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      event_valid_r <= 1'b0;
      event_r <= '0;
    end else if (load_slot) begin
      event_valid_r <= out_pend || in_pend;
      if (out_pend) begin
        event_r <= '{group: GROUP_OUTPUT, index: out_idx, rising: out_rise, stamp: out_stamp};
      end else if (in_pend) begin
        event_r <= '{group: GROUP_INPUT, index: in_idx, rising: in_rise, stamp: in_stamp};
      end
    end
  end

  assign event_valid_o = event_valid_r;
  assign event_o = event_r;

  // sticky status, write one to clear, a same-cycle set wins
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SENT_BIT] = event_valid_r && event_ready_i;
    irq_set[IRQ_LOST_BIT] = out_lost || in_lost;
    irq_clr = (wr_en && paddr_i == IRQ_STATUS_OFS) ? pwdata_i[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_status_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      if (wr_en && paddr_i == IRQ_MASK_OFS) begin
        irq_mask_r <= pwdata_i[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_r & irq_mask_r);
    end
  end

endmodule

/* File: testbench/virtual_logic_io_bank_properties.sv */
// port assertions for the virtual logic i/o bank
`timescale 1ns/1ps
module virtual_logic_io_bank_properties import vio_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
  parameter int unsigned PULSE_MS = PULSE_MS_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic pready_o,
  // commands and levels
  input wire logic [CHANNELS-1:0] mimic_set_i,
  input wire logic [CHANNELS-1:0] mimic_clr_i,
  input wire logic [CHANNELS-1:0] vin_o,
  // event stream
  input wire logic event_valid_o,
  input wire vio_event_s event_o,
  input wire logic event_ready_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr_done;
  logic mode0_r;
  logic clr0_r;
  logic [CHANNELS-1:0] apb_set, apb_clr, vin_r, cmd_r, clr_only_r;
  int unsigned cnt_r;
  // completed apb writes decoded per command word
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign apb_set = (wr_done && paddr_i == VIN_SET_OFS) ? pwdata_i : '0;
  assign apb_clr = (wr_done && paddr_i == VIN_CLR_OFS) ? pwdata_i : '0;
  // shadows of last cycle; mode of input 0 mirrored since it is internal
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vin_r <= '0;
      cmd_r <= '0;
      clr_only_r <= '0;
      clr0_r <= 1'b0;
      mode0_r <= 1'b0;
    end else begin
      vin_r <= vin_o;
      cmd_r <= mimic_set_i | apb_set;
      clr_only_r <= mimic_clr_i & ~mimic_set_i;
      clr0_r <= mimic_clr_i[0] | apb_clr[0];
      if (wr_done && paddr_i == VIN_MODE_OFS) mode0_r <= pwdata_i[0];
    end
  end
  // high time of input 0, restarted by every set command
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || mimic_set_i[0] || apb_set[0] || !vin_o[0]) cnt_r <= 0;
    else cnt_r <= cnt_r + 1;
  end
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  property p_answer;
    s_access |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer late");
  property p_rst;
    $rose(rst_n_i) |-> vin_o == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("input kept over reset");
  property p_set;
    mimic_set_i != '0 |=> (vin_o & $past(mimic_set_i)) == $past(mimic_set_i);
  endproperty
  a_set: assert property (p_set) else $error("set command lost");
  property p_clr;
    (mimic_clr_i & ~mimic_set_i) != '0 && !psel_i |=> (vin_o & clr_only_r) == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear command lost");
  property p_cmd;
    (vin_o & ~vin_r & ~cmd_r) == '0;
  endproperty
  a_cmd: assert property (p_cmd) else $error("input rose without command");
  property p_hold;
    event_valid_o && !event_ready_i |=> event_valid_o && $stable(event_o);
  endproperty
  a_hold: assert property (p_hold) else $error("event dropped while waiting");
  property p_max;
    mode0_r && vin_o[0] |-> cnt_r <= PULSE_MS * MS_CYCLES + 1;
  endproperty
  a_max: assert property (p_max) else $error("pulse too long");
  property p_min;
    mode0_r && $fell(vin_o[0]) && !clr0_r |-> $past(cnt_r) >= (PULSE_MS - 1) * MS_CYCLES - 2;
  endproperty
  a_min: assert property (p_min) else $error("pulse too short");
endmodule
bind virtual_logic_io_bank virtual_logic_io_bank_properties #(
  .MS_CYCLES(MS_CYCLES),
  .PULSE_MS(PULSE_MS)
) u_virtual_logic_io_bank_properties (
  .mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .mimic_set_i, .mimic_clr_i, .vin_o, .event_valid_o, .event_o, .event_ready_i
);

/* File: testbench/user_side_model.sv */
// user logic and event buffer stand-in on the far side of the bank
`timescale 1ns/1ps
module user_side_model import vio_pkg::*; #(
  parameter int unsigned STRETCH = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // bank side
  input wire logic [CHANNELS-1:0] vin_i,
  output logic [CHANNELS-1:0] vout_o,
  output logic ready_o,
  // bench control
  input wire logic [CHANNELS-1:0] user_i,
  input wire logic stall_i
);
  logic [7:0] hold_r;
  // falling-edge delay gate lengthens input 0 pulses
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hold_r <= '0;
    end else if (vin_i[0]) begin
      hold_r <= 8'(STRETCH);
    end else if (hold_r != '0) begin
      hold_r <= hold_r - 8'h01;
    end
  end
  // user results; output 0 also carries the stretched pulse
  assign vout_o = {user_i[CHANNELS-1:1], user_i[0] | vin_i[0] | (hold_r != '0)};
  // a full event buffer is modelled by stalling
  assign ready_o = !stall_i;
endmodule

/* File: testbench/virtual_logic_io_bank_tb_top.sv */
// self-checking bench for the virtual logic i/o bank
`timescale 1ns/1ps
module virtual_logic_io_bank_tb_top import vio_pkg::*;;
  localparam int unsigned MSC = 10;
  localparam int unsigned PMS = 5;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, stall = 1'b0, err;
  logic pready_o, pslverr_o, event_valid_o, event_ready_i, irq_o;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [DATA_W-1:0] pwdata_i = '0, prdata_o, rd, s0;
  logic [CHANNELS-1:0] mimic_set_i = '0, mimic_clr_i = '0, user = '0;
  logic [CHANNELS-1:0] vout_i, vin_o, block_o, group_sel_o, relay_o, led_o;
  vio_event_s event_o, ev;
  int n_mismatch = 0, n_checks = 0;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
  always #2.5 mclk_i = ~mclk_i;
  virtual_logic_io_bank #(.MS_CYCLES(MSC), .PULSE_MS(PMS)) u_virtual_logic_io_bank (
    .mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .mimic_set_i, .mimic_clr_i, .vout_i, .vin_o, .block_o,
    .group_sel_o, .relay_o, .led_o, .event_valid_o, .event_o, .event_ready_i, .irq_o);
  user_side_model #(.STRETCH(8)) u_user_side_model (.mclk_i, .rst_n_i, .vin_i(vin_o),
    .vout_o(vout_i), .ready_o(event_ready_i), .user_i(user), .stall_i(stall));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    print_verdict();
  endtask
  // one apb transfer, entered just after an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk_i);
      if (pready_o === 1'b1) break;
    end
    if (k == 20) timeout();
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // next accepted event must match group, index and direction
  task automatic get_evt(input logic g, input logic [IDX_W-1:0] i, input logic r);
    int k;
    for (k = 0; k < 50; k++) begin
      @(negedge mclk_i);
      if (event_valid_o === 1'b1 && event_ready_i === 1'b1) break;
    end
    if (k == 50) timeout();
    ev = event_o;
    `CHK("event", {g, i, r}, {ev.group, ev.index, ev.rising})
    @(posedge mclk_i);
  endtask
  task automatic drain();
    int q = 0;
    repeat (200) begin
      @(posedge mclk_i);
      q = event_valid_o ? 0 : q + 1;
      if (q > 6) break;
    end
  endtask
  task automatic t_reset();
    apb(1'b0, VIN_LEVEL_OFS, '0);
    `CHK("vin_level", WORD_ZERO, rd)
    apb(1'b0, EVT_FILTER_OFS, '0);
    `CHK("filter", 32'h0000_0003, rd)
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_hold();
    mimic_set_i <= 32'h0000_0008;
    @(posedge mclk_i);
    mimic_set_i <= '0;
    get_evt(GROUP_INPUT, 5'h03, 1'b1);
    repeat (60) @(posedge mclk_i);
    `CHK("hold", 1'b1, vin_o[3])
    apb(1'b1, VIN_CLR_OFS, 32'h0000_0008);
    `CHK("clear", 1'b0, vin_o[3])
    get_evt(GROUP_INPUT, 5'h03, 1'b0);
    apb(1'b1, VIN_SET_OFS, 32'h0000_0030);
    mimic_clr_i <= 32'h0000_0010;
    @(posedge mclk_i);
    mimic_clr_i <= '0;
    @(posedge mclk_i);
    `CHK("mimic_clr", 2'h2, vin_o[5:4])
    drain();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    `CHK("restart", WORD_ZERO, vin_o)
  endtask
  task automatic t_pulse();
    int n;
    apb(1'b1, ROUTE_RELAY_OFS, 32'h0000_0001);
    apb(1'b1, VIN_MODE_OFS, 32'h0000_0001);
    apb(1'b1, VIN_SET_OFS, 32'h0000_0001);
    repeat (20) @(posedge mclk_i);
    mimic_set_i <= 32'h0000_0001;
    @(posedge mclk_i);
    mimic_set_i <= '0;
    for (n = 0; n < 200 && vin_o[0] === 1'b1; n++) @(posedge mclk_i);
    `CHK("pulse", 1'b1, n >= (PMS-1)*MSC-2 && n <= PMS*MSC+2)
    repeat (4) @(posedge mclk_i);
    `CHK("relay_on", 1'b1, relay_o[0])
    repeat (12) @(posedge mclk_i);
    `CHK("relay_off", 1'b0, relay_o[0])
    apb(1'b1, VIN_MODE_OFS, '0);
    drain();
  endtask
  task automatic t_filter();
    apb(1'b1, EVT_FILTER_OFS, 32'h0000_0001);
    apb(1'b0, MS_STAMP_OFS, '0);
    s0 = rd;
    user <= 32'h0000_0080;
    get_evt(GROUP_OUTPUT, 5'h07, 1'b1);
    `CHK("stamp", 1'b1, ev.stamp >= s0 && ev.stamp <= s0 + 1)
    apb(1'b0, VOUT_LEVEL_OFS, '0);
    `CHK("vout_level", 32'h0000_0080, rd)
    stall <= 1'b1;
    user <= '0;
    repeat (10) @(posedge mclk_i);
    `CHK("off_filtered", 1'b0, event_valid_o)
    apb(1'b1, EVT_FILTER_OFS, 32'h0000_0002);
    user <= 32'h0000_0080;
    repeat (10) @(posedge mclk_i);
    `CHK("on_filtered", 1'b0, event_valid_o)
    stall <= 1'b0;
    user <= '0;
    get_evt(GROUP_OUTPUT, 5'h07, 1'b0);
    apb(1'b1, EVT_FILTER_OFS, 32'h0000_0003);
    apb(1'b1, ROUTE_LED_OFS, 32'hFFFF_FFFF);
    apb(1'b1, ROUTE_BLOCK_OFS, 32'h0000_00F0);
    apb(1'b1, ROUTE_GROUP_OFS, 32'h0F00_0000);
    user <= '1;
    for (int i = 0; i < CHANNELS; i++) get_evt(GROUP_OUTPUT, 5'(i), 1'b1);
    `CHK("led", 32'hFFFF_FFFF, led_o)
    `CHK("block", 32'h0000_00F0, block_o)
    `CHK("group_sel", 32'h0F00_0000, group_sel_o)
    user <= '0;
    drain();
  endtask
  task automatic t_irq();
    apb(1'b1, IRQ_STATUS_OFS, 32'h0000_0003);
    apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
    `CHK("irq_idle", 1'b0, irq_o)
    user <= 32'h0000_0200;
    get_evt(GROUP_OUTPUT, 5'h09, 1'b1);
    repeat (3) @(posedge mclk_i);
    `CHK("irq_on", 1'b1, irq_o)
    apb(1'b1, IRQ_STATUS_OFS, 32'h0000_0001);
    repeat (2) @(posedge mclk_i);
    `CHK("irq_clear", 1'b0, irq_o)
    stall <= 1'b1;
    user <= 32'h0000_0000;
    @(posedge mclk_i);
    user <= 32'h0000_0200;
    @(posedge mclk_i);
    user <= 32'h0000_0000;
    repeat (4) @(posedge mclk_i);
    stall <= 1'b0;
    drain();
    apb(1'b0, IRQ_STATUS_OFS, '0);
    `CHK("lost", 1'b1, rd[IRQ_LOST_BIT])
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_hold();
    t_pulse();
    t_filter();
    t_irq();
    print_verdict();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk_i);
    timeout();
  end
endmodule
